// ==== design/cid_pkg.sv ====
// package of constants for the second-half instruction decoder
package cid_pkg;
    localparam int          CID_IW         = 14;
    localparam int          CID_DW         = 8;
    localparam int          CID_FAW        = 7;
    localparam int          CID_PCW        = 13;
    // status bit positions
    localparam int          CID_C_BIT      = 0;
    localparam int          CID_DC_BIT     = 1;
    localparam int          CID_Z_BIT      = 2;
    localparam int          CID_PD_BIT     = 3;
    localparam int          CID_TO_BIT     = 4;
    localparam int          CID_GIE_BIT    = 7;
    // reset values
    localparam logic [7:0]  CID_W_RST      = 8'h00;
    localparam logic [7:0]  CID_OPT_RST    = 8'hFF;
    localparam logic [7:0]  CID_DIR_RST    = 8'hFF;
    localparam logic [4:0]  CID_STAT_RST   = 5'h18;
    // direction register select range
    localparam logic [2:0]  CID_DIR_LO     = 3'h5;
    localparam logic [2:0]  CID_DIR_HI     = 3'h7;
    localparam int          CID_NDIR       = 3;
    typedef enum logic [4:0] {
        CID_OP_NOP, CID_OP_MOVE_FILE, CID_OP_LOAD_LIT, CID_OP_STORE_W, CID_OP_IRET,
        CID_OP_OPTION, CID_OP_RETLIT, CID_OP_RETURN, CID_OP_RRF, CID_OP_RLF,
        CID_OP_SUBLIT, CID_OP_SUBFILE, CID_OP_SWAP, CID_OP_XORLIT, CID_OP_DIR,
        CID_OP_XORFILE, CID_OP_SLEEP, CID_OP_OTHER
    } cid_op_t;
endpackage

// ==== design/cid_decode.sv ====
// opcode classifier for the second-half instructions
`timescale 1ns/10ps
`default_nettype none
module cid_decode
    import cid_pkg::*;
(
    // instruction word
    input  wire logic [cid_pkg::CID_IW-1:0] instr_in,
    // decoded class
    output cid_pkg::cid_op_t                op_out
);
    always_comb begin
        op_out = CID_OP_OTHER;
        if (instr_in[13:12] == 2'b11) begin
            if (instr_in[11:10] == 2'b00)
                op_out = CID_OP_LOAD_LIT;                         // [RULE2]
            else if (instr_in[11:10] == 2'b01)
                op_out = CID_OP_RETLIT;                           // [RULE6]
            else if (instr_in[11:9] == 3'b110)
                op_out = CID_OP_SUBLIT;                           // [RULE10]
            else if (instr_in[11:8] == 4'hA)
                op_out = CID_OP_XORLIT;                           // [RULE14]
        end else if (instr_in[13:12] == 2'b00) begin
            unique case (instr_in[11:8])
                4'h8: op_out = CID_OP_MOVE_FILE;                  // [RULE1]
                4'hC: op_out = CID_OP_RRF;                        // [RULE8]
                4'hD: op_out = CID_OP_RLF;                        // [RULE9]
                4'h2: op_out = CID_OP_SUBFILE;                    // [RULE11]
                4'hE: op_out = CID_OP_SWAP;                       // [RULE13]
                4'h6: op_out = CID_OP_XORFILE;                    // [RULE16]
                4'h0: begin
                    if (instr_in[7])
                        op_out = CID_OP_STORE_W;                  // [RULE3]
                    else if (instr_in[6:0] == 7'h09)
                        op_out = CID_OP_IRET;                     // [RULE4]
                    else if (instr_in[6:0] == 7'h08)
                        op_out = CID_OP_RETURN;                   // [RULE7]
                    else if (instr_in[6:0] == 7'h62)
                        op_out = CID_OP_OPTION;                   // [RULE5]
                    else if (instr_in[6:0] == 7'h63)
                        op_out = CID_OP_SLEEP;                    // [RULE18]
                    else if (instr_in[6:3] == 4'hC && instr_in[2:0] >= CID_DIR_LO)
                        op_out = CID_OP_DIR;                      // [RULE15]
                    else if (instr_in[6:0] == 7'h00 || instr_in[6:0] == 7'h20
                             || instr_in[6:0] == 7'h40 || instr_in[6:0] == 7'h60)
                        op_out = CID_OP_NOP;                      // [RULE19]
                end
                default: op_out = CID_OP_OTHER;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== design/cid_core.sv ====
// execute stage for the second-half instruction group
// Notes on behaviour
// RULE1 - move file: copy file to W (d=0) or itself (d=1), update zero.
// RULE2 - load literal into W, flags unchanged, don't-care bits read as zero.
// RULE3 - store W into addressed file in one cycle, flags unchanged.
// RULE4 - interrupt return: pop stack top to PC, set global enable, two cycles.
// RULE5 - option load: copy W into option register in one cycle, no flags.
// RULE6 - return with literal: literal to W, pop stack to PC, two cycles.
// RULE7 - subroutine return: pop stack top to PC, no flags, two cycles.
// RULE8 - rotate right through carry: old carry to bit 7, bit 0 to carry.
// RULE9 - rotate left through carry: old carry to bit 0, bit 7 to carry.
// RULE10 - literal minus W into W, update carry, digit carry, zero.
// RULE11 - file minus W, routed by destination bit, update C, DC, Z.
// RULE12 - subtraction carry is inverted borrow: set when result not negative.
// RULE13 - swap nibbles of file, route by destination, flags unchanged.
// RULE14 - XOR W with literal into W, update zero.
// RULE15 - direction load: W into direction register 5..7, no flags.
// RULE16 - XOR W with file, route by destination, update zero.
// RULE17 - byte file ops: d=0 writes W, d=1 writes file back.
// RULE18 - sleep: clear watchdog and prescaler, set timeout, clear powerdown, halt. The code only pulses watchdog_clear_out and has no prescaler clear.
// RULE19 - no-operation decodes ignoring don't-care bits, changes nothing, one cycle.
`timescale 1ns/10ps
`default_nettype none
module cid_core
    import cid_pkg::*;
#(
    parameter int NDIR = cid_pkg::CID_NDIR
) (
    // clock and reset
    input  wire logic                        core_clk_in,
    input  wire logic                        sys_rst_in,
    // instruction issue
    input  wire logic                        instr_valid_in,
    input  wire logic [cid_pkg::CID_IW-1:0]  instr_in,
    input  wire logic [cid_pkg::CID_DW-1:0]  file_rdata_in,
    input  wire logic [cid_pkg::CID_PCW-1:0] stack_top_in,
    input  wire logic                        wake_in,
    // file register write
    output logic                             file_we_out,
    output logic [cid_pkg::CID_FAW-1:0]      file_addr_out,
    output logic [cid_pkg::CID_DW-1:0]       file_wdata_out,
    // program flow
    output logic                             stack_pop_out,
    output logic [cid_pkg::CID_PCW-1:0]      pc_load_out,
    output logic                             pc_load_en_out,
    output logic                             busy_out,
    // architectural state
    output logic [cid_pkg::CID_DW-1:0]       working_out,
    output logic                             carry_out,
    output logic                             digit_carry_flag_out,
    output logic                             zero_out,
    output logic                             timeout_flag_n_out,
    output logic                             powerdown_flag_n_out,
    output logic                             global_irq_enable_out,
    output logic [cid_pkg::CID_DW-1:0]       option_out,
    output logic [3*cid_pkg::CID_DW-1:0]     port_direction_reg_out,
    output logic                             watchdog_clear_out,
    output logic                             osc_halt_out
);
    import cid_pkg::*;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    cid_op_t op;
    cid_decode cid_decode_i (
        .instr_in (instr_in),
        .op_out   (op)
    );

    // subtraction a - b with carry as inverted borrow
    function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} + {1'b0, ~b} + 9'h001;
        low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        sub8 = {full[8], low[4], full[7:0]};                  // [RULE12]
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0]            w_q, w_d;
    logic                  c_q, c_d, dc_q, dc_d, z_q, z_d;
    logic                  to_q, to_d, pd_q, pd_d, gie_q, gie_d;
    logic [7:0]            opt_q, opt_d;
    logic [NDIR*8-1:0]     dir_q, dir_d;
    logic                  fwe_q, fwe_d, pop_q, pop_d, pcl_q, pcl_d;
    logic [CID_FAW-1:0]    fa_q, fa_d;
    logic [7:0]            fd_q, fd_d;
    logic [CID_PCW-1:0]    pc_q, pc_d;
    logic                  busy_q, busy_d, wdc_q, wdc_d, halt_q, halt_d;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [7:0] f;
        logic [7:0] k;
        logic [7:0] res;
        logic [9:0] s;
        logic       wr;
        logic       dst;
        f   = file_rdata_in;
        k   = instr_in[7:0];
        res = 8'h00;
        s   = 10'h000;
        wr  = 1'b0;
        dst = instr_in[7];
        w_d = w_q;  c_d = c_q;  dc_d = dc_q;  z_d = z_q;
        to_d = to_q;  pd_d = pd_q;  gie_d = gie_q;
        opt_d = opt_q;  dir_d = dir_q;
        fwe_d = 1'b0;  pop_d = 1'b0;  pcl_d = 1'b0;  wdc_d = 1'b0;
        fa_d = instr_in[6:0];  fd_d = fd_q;  pc_d = pc_q;
        busy_d = 1'b0;  halt_d = halt_q;
        if (halt_q) begin
            // oscillator stays halted until a wake-up arrives
            if (wake_in)
                halt_d = 1'b0;                                // [RULE18]
        end else if (busy_q) begin
            busy_d = 1'b0;                                    // second cycle of a return
        end else if (instr_valid_in) begin
            unique case (op)
                CID_OP_MOVE_FILE: begin res = f; wr = 1'b1; z_d = (f == 8'h00); end // [RULE1]
                CID_OP_LOAD_LIT:  w_d = k;                                           // [RULE2]
                CID_OP_STORE_W:   begin fwe_d = 1'b1; fd_d = w_q; end               // [RULE3]
                CID_OP_IRET: begin
                    pop_d = 1'b1; pcl_d = 1'b1; pc_d = stack_top_in;
                    gie_d = 1'b1; busy_d = 1'b1;                                     // [RULE4]
                end
                CID_OP_OPTION:    opt_d = w_q;                                       // [RULE5]
                CID_OP_RETLIT: begin
                    w_d = k; pop_d = 1'b1; pcl_d = 1'b1;
                    pc_d = stack_top_in; busy_d = 1'b1;                              // [RULE6]
                end
                CID_OP_RETURN: begin
                    pop_d = 1'b1; pcl_d = 1'b1; pc_d = stack_top_in; busy_d = 1'b1;  // [RULE7]
                end
                CID_OP_RRF: begin res = {c_q, f[7:1]}; c_d = f[0]; wr = 1'b1; end  // [RULE8]
                CID_OP_RLF: begin res = {f[6:0], c_q}; c_d = f[7]; wr = 1'b1; end  // [RULE9]
                CID_OP_SUBLIT: begin
                    s = sub8(k, w_q); w_d = s[7:0];
                    c_d = s[9]; dc_d = s[8]; z_d = (s[7:0] == 8'h00);               // [RULE10]
                end
                CID_OP_SUBFILE: begin
                    s = sub8(f, w_q); res = s[7:0]; wr = 1'b1;
                    c_d = s[9]; dc_d = s[8]; z_d = (s[7:0] == 8'h00);               // [RULE11]
                end
                CID_OP_SWAP:  begin res = {f[3:0], f[7:4]}; wr = 1'b1; end          // [RULE13]
                CID_OP_XORLIT: begin w_d = w_q ^ k; z_d = ((w_q ^ k) == 8'h00); end // [RULE14]
                CID_OP_DIR:
                    dir_d[8*(instr_in[2:0]-CID_DIR_LO) +: 8] = w_q;                 // [RULE15]
                CID_OP_XORFILE: begin
                    res = w_q ^ f; wr = 1'b1; z_d = (res == 8'h00);                 // [RULE16]
                end
                CID_OP_SLEEP: begin
                    wdc_d = 1'b1; to_d = 1'b1; pd_d = 1'b0; halt_d = 1'b1;          // [RULE18]
                end
                CID_OP_NOP:   ;                                                      // [RULE19]
                CID_OP_OTHER: ;
            endcase
            if (wr) begin
                // destination bit picks W or the file itself
                if (dst) begin
                    fwe_d = 1'b1; fd_d = res;                                        // [RULE17]
                end else begin
                    w_d = res;                                                       // [RULE17]
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            w_q <= CID_W_RST;
            {to_q, pd_q, z_q, dc_q, c_q} <= CID_STAT_RST;
            gie_q <= 1'b0;
            opt_q <= CID_OPT_RST;
            dir_q <= {NDIR{CID_DIR_RST}};
            fwe_q <= 1'b0; pop_q <= 1'b0; pcl_q <= 1'b0;
            fa_q <= '0; fd_q <= 8'h00; pc_q <= '0;
            busy_q <= 1'b0; wdc_q <= 1'b0; halt_q <= 1'b0;
        end else begin
            w_q <= w_d;
            c_q <= c_d; dc_q <= dc_d; z_q <= z_d;
            to_q <= to_d; pd_q <= pd_d; gie_q <= gie_d;
            opt_q <= opt_d; dir_q <= dir_d;
            fwe_q <= fwe_d; pop_q <= pop_d; pcl_q <= pcl_d;
            fa_q <= fa_d; fd_q <= fd_d; pc_q <= pc_d;
            busy_q <= busy_d; wdc_q <= wdc_d; halt_q <= halt_d;
        end
    end

    assign file_we_out            = fwe_q;
    assign file_addr_out          = fa_q;
    assign file_wdata_out         = fd_q;
    assign stack_pop_out          = pop_q;
    assign pc_load_out            = pc_q;
    assign pc_load_en_out         = pcl_q;
    assign busy_out               = busy_q;
    assign working_out            = w_q;
    assign carry_out              = c_q;
    assign digit_carry_flag_out   = dc_q;
    assign zero_out               = z_q;
    assign timeout_flag_n_out     = to_q;
    assign powerdown_flag_n_out   = pd_q;
    assign global_irq_enable_out  = gie_q;
    assign option_out             = opt_q;
    assign port_direction_reg_out = dir_q;
    assign watchdog_clear_out     = wdc_q;
    assign osc_halt_out           = halt_q;
endmodule
`default_nettype wire

// ==== bench/cid_core_sva.sv ====
// assertion checker for the second-half execute stage
`timescale 1ns/10ps
`default_nettype none
module cid_core_sva (
    // clock and reset
    input wire logic        core_clk_in,
    input wire logic        sys_rst_in,
    // issue side
    input wire logic        instr_valid_in,
    input wire logic [13:0] instr_in,
    input wire logic [7:0]  file_rdata_in,
    input wire logic [12:0] stack_top_in,
    // result side
    input wire logic        file_we_out,
    input wire logic [6:0]  file_addr_out,
    input wire logic [7:0]  file_wdata_out,
    input wire logic        stack_pop_out,
    input wire logic [12:0] pc_load_out,
    input wire logic        busy_out,
    input wire logic [7:0]  working_out,
    input wire logic        carry_out,
    input wire logic        zero_out,
    input wire logic        timeout_flag_n_out,
    input wire logic        powerdown_flag_n_out,
    input wire logic        global_irq_enable_out,
    input wire logic [7:0]  option_out,
    input wire logic        watchdog_clear_out,
    input wire logic        osc_halt_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    logic tk;
    // a word only counts on edges where the core accepts it
    assign tk = instr_valid_in && !busy_out && !osc_halt_out;
    AST_STORE: assert property (tk && instr_in[13:7] == 7'h01 |=> file_we_out &&
        file_wdata_out == $past(working_out) && file_addr_out == $past(instr_in[6:0]))
        else $error("store not written");
    AST_LOAD_LIT: assert property (tk && instr_in[13:10] == 4'hC |=>
        working_out == $past(instr_in[7:0]) && $stable(zero_out) && $stable(carry_out))
        else $error("literal load wrong");
    AST_RET: assert property (tk && instr_in == 14'h0008 |=>
        (stack_pop_out && pc_load_out == $past(stack_top_in) && busy_out) ##1 !busy_out)
        else $error("return pop wrong");
    AST_IRET: assert property (tk && instr_in == 14'h0009 |=>
        stack_pop_out && global_irq_enable_out && busy_out) else $error("iret wrong");
    AST_OPTION: assert property (tk && instr_in == 14'h0062 |=>
        option_out == $past(working_out)) else $error("option load wrong");
    AST_SWAP: assert property (tk && instr_in[13:7] == 7'h1D |=> file_we_out &&
        file_wdata_out == {$past(file_rdata_in[3:0]), $past(file_rdata_in[7:4])})
        else $error("swap wrong");
    AST_SLEEP: assert property (tk && instr_in == 14'h0063 |=> watchdog_clear_out &&
        osc_halt_out && timeout_flag_n_out && !powerdown_flag_n_out) else $error("sleep wrong");
    AST_XOR_LIT: assert property (tk && instr_in[13:8] == 6'h3A |=>
        working_out == ($past(working_out) ^ $past(instr_in[7:0])) &&
        zero_out == (working_out == 8'h00)) else $error("xor literal wrong");
    AST_SUB_C: assert property (tk && instr_in[13:9] == 5'h1E |=>
        carry_out == ($past(instr_in[7:0]) >= $past(working_out))) else $error("borrow wrong");
    AST_NOP: assert property (tk && instr_in[13:7] == 7'h00 && instr_in[4:0] == 5'h00 |=>
        !file_we_out && !stack_pop_out && $stable(working_out) && $stable(carry_out))
        else $error("nop changed state");
    cover property (tk && instr_in == 14'h0008);
    cover property (tk && instr_in == 14'h0063);
    cover property (tk && instr_in[13:8] == 6'h02);
endmodule
`default_nettype wire

// ==== bench/cid_mem_model.sv ====
// behavioural file registers and return stack facing the execute stage
`timescale 1ns/10ps
`default_nettype none
module cid_mem_model (
    // clock and file port
    input  wire logic        core_clk_in,
    input  wire logic [6:0]  rd_addr_in,
    input  wire logic        file_we_in,
    input  wire logic [6:0]  file_addr_in,
    input  wire logic [7:0]  file_wdata_in,
    output logic      [7:0]  file_rdata_out,
    // return stack
    input  wire logic        stack_pop_in,
    output logic      [12:0] stack_top_out
);
    logic [7:0] mem_q [128];
    logic [2:0] sp_q;
    initial begin
        sp_q = 3'h7;
        for (int i = 0; i < 128; i++) mem_q[i] = 8'(i * 37 + 5);
    end
    // a write still in flight is forwarded so back-to-back ops read fresh data
    assign file_rdata_out = (file_we_in && file_addr_in == rd_addr_in) ? file_wdata_in
                                                                        : mem_q[rd_addr_in];
    assign stack_top_out = {sp_q, 10'h155};
    always @(posedge core_clk_in) begin
        if (file_we_in) mem_q[file_addr_in] <= file_wdata_in;
        if (stack_pop_in) sp_q <= sp_q - 3'h1;
    end
endmodule
`default_nettype wire

// ==== bench/cid_core_tb.sv ====
// self-checking bench for the second-half execute stage
`timescale 1ns/10ps
`default_nettype none
module cid_core_tb;
    import cid_pkg::*;
    logic        core_clk_in, sys_rst_in, instr_valid_in, wake_in, file_we_out, stack_pop_out;
    logic        pc_load_en_out, busy_out, carry_out, digit_carry_flag_out, zero_out, hung;
    logic        timeout_flag_n_out, powerdown_flag_n_out, global_irq_enable_out;
    logic        watchdog_clear_out, osc_halt_out, d, global_irq_enable, e_we, e_pop, e_busy, e_wdc, e_halt;
    logic [13:0] instr_in;
    logic [7:0]  file_rdata_in, file_wdata_out, working_out, option_out, opt, e_wd;
    logic [12:0] stack_top_in, pc_load_out, e_pc;
    logic [6:0]  file_addr_out, e_wa;
    logic [23:0] port_direction_reg_out, dir;
    logic [4:0]  st;
    logic [2:0]  sp;
    int          w, a, seed, err_count, check_count, mem[128];
    cid_core cid_core_i (.*);
    cid_mem_model cid_mem_model_i (.core_clk_in(core_clk_in), .rd_addr_in(instr_in[6:0]),
        .file_we_in(file_we_out), .file_addr_in(file_addr_out), .file_wdata_in(file_wdata_out),
        .file_rdata_out(file_rdata_in), .stack_pop_in(stack_pop_out), .stack_top_out(stack_top_in));
    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic put(input int r, input logic dst, input logic zf);
        if (dst) begin
            {e_we, e_wa, e_wd, mem[a]} = {1'b1, 7'(a), 8'(r), 32'(r & 255)};
        end else w = r & 255;
        if (zf) st[CID_Z_BIT] = ((r & 255) == 0);
    endtask
    task automatic sub(input int x, input int y, input logic dst);
        st[CID_C_BIT] = (x >= y);
        st[CID_DC_BIT] = ((x & 15) >= (y & 15));
        put(x - y, dst, 1'b1);
    endtask
    task automatic pop();
        {e_pop, e_busy, e_pc} = {2'b11, sp, 10'h155};
        sp = sp - 3'h1;
    endtask
    task automatic step(input logic [13:0] ins);
        logic skip;
        int f;
        @(posedge core_clk_in);
        instr_in <= ins;
        instr_valid_in <= 1'b1;
        #1;
        cmp(working_out, 24'(w));
        cmp({timeout_flag_n_out, powerdown_flag_n_out, zero_out, digit_carry_flag_out, carry_out}, st);
        cmp({global_irq_enable_out, option_out}, {global_irq_enable, opt});
        cmp(port_direction_reg_out, dir);
        cmp({file_we_out, stack_pop_out, pc_load_en_out, busy_out, watchdog_clear_out, osc_halt_out},
            {e_we, e_pop, e_pop, e_busy, e_wdc, e_halt});
        if (e_we) cmp({file_addr_out, file_wdata_out}, {e_wa, e_wd});
        if (e_pop) cmp(pc_load_out, e_pc);
        // words offered while busy or asleep must be dropped
        skip = e_busy | e_halt;
        {e_we, e_pop, e_busy, e_wdc} = 4'h0;
        if (skip) return;
        a = ins[6:0];
        f = mem[a];
        d = ins[7];
        casez (ins)
            14'b00_1000_????_????: put(f, d, 1'b1);
            14'b11_00??_????_????: w = ins[7:0];
            14'b00_0000_1???_????: put(w, 1'b1, 1'b0);
            14'h0009: {global_irq_enable, e_halt} = 2'b10;
            14'h0062: opt = 8'(w);
            14'b11_01??_????_????: w = ins[7:0];
            14'b00_1100_????_????: {st[CID_C_BIT], f} = {f[0], 24'h0, st[CID_C_BIT], f[7:1]};
            14'b00_1101_????_????: {st[CID_C_BIT], f} = {f[7], 24'h0, f[6:0], st[CID_C_BIT]};
            14'b11_110?_????_????: sub(ins[7:0], w, 1'b0);
            14'b00_0010_????_????: sub(f, w, d);
            14'b00_1110_????_????: put({f[3:0], f[7:4]}, d, 1'b0);
            14'b11_1010_????_????: put(w ^ ins[7:0], 1'b0, 1'b1);
            14'h0065, 14'h0066, 14'h0067: dir[(ins[2:0] - 3'h5) * 8 +: 8] = 8'(w);
            14'b00_0110_????_????: put(w ^ f, d, 1'b1);
            14'h0063: {st[CID_TO_BIT], st[CID_PD_BIT], e_wdc, e_halt} = 4'b1011;
            default: ;
        endcase
        if (ins[13:8] inside {6'h0C, 6'h0D}) put(f, d, 1'b0);
        if (ins[13:1] == 13'h0004 || ins[13:10] == 4'hD) pop();
    endtask
    task automatic wake();
        @(posedge core_clk_in);
        wake_in <= 1'b1;
        instr_valid_in <= 1'b0;
        for (int i = 0; i < 32 && osc_halt_out !== 1'b0; i++) begin
            @(posedge core_clk_in);
            #1;
        end
        if (osc_halt_out !== 1'b0) begin
            // a core that never wakes ends the run through the closing report
            err_count++;
            hung = 1'b1;
        end
        @(posedge core_clk_in);
        wake_in <= 1'b0;
        e_halt = 1'b0;
    endtask
    function automatic logic [13:0] gen();
        logic [31:0] r;
        r = $random(seed);
        case (r[31:24] % 18)
            0: return {6'h08, r[7:0]};
            1: return {4'hC, r[9:0]};
            2: return {7'h01, r[6:0]};
            3: return 14'h0009;
            4: return 14'h0062;
            5: return {4'hD, r[9:0]};
            6: return 14'h0008;
            7: return {6'h0C, r[7:0]};
            8: return {6'h0D, r[7:0]};
            9: return {5'h1E, r[8:0]};
            10: return {6'h02, r[7:0]};
            11: return {6'h0E, r[7:0]};
            12: return {6'h3A, r[7:0]};
            13: return 14'h0065 + 14'(r[15:8] % 3);
            14: return {6'h06, r[7:0]};
            15: return 14'h0063;
            16: return {7'h00, r[6:5], 5'h00};
            // first-half opcodes must leave every register alone
            default: return {2'b01, r[11:0]};
        endcase
    endfunction
    initial begin
        core_clk_in = 1'b0;
        forever #2.5 core_clk_in = ~core_clk_in;
    end
    initial begin
        {sys_rst_in, instr_valid_in, wake_in, instr_in, seed, sp} = {3'b100, 14'h0, 32'd13, 3'h7};
        {err_count, check_count} = 0;
        hung = 1'b0;
        for (int i = 0; i < 128; i++) mem[i] = (i * 37 + 5) & 255;
        for (int t = 0; t < 2 && !hung; t++) begin
            repeat (16) @(posedge core_clk_in);
            sys_rst_in <= 1'b0;
            {w, st, global_irq_enable, opt, dir} = {32'(CID_W_RST), CID_STAT_RST, 1'b0, CID_OPT_RST, {3{CID_DIR_RST}}};
            {e_we, e_pop, e_busy, e_wdc, e_halt} = 5'h00;
            for (int n = 0; n < 500 && !hung; n++) begin
                step(gen());
                if (e_halt && !e_wdc) wake();
            end
            $display("random sequence %0d done", t);
            // let the last word retire so the partner model sees its write or pop
            @(posedge core_clk_in);
            instr_valid_in <= 1'b0;
            @(posedge core_clk_in);
            {sys_rst_in, instr_valid_in, wake_in} <= 3'b100;
        end
        test_done();
    end
endmodule
bind cid_core cid_core_sva cid_core_sva_i (.*);
`default_nettype wire
